// file: hks_cfg.svh
// constants for the hexadecimal keypad scanner: offsets, fields, resets, timing
// assumes a 50 MHz system clock and a byte-addressed register port
// Overview of operation
// - drive four keypad selection lines on output bits 0 to 3 in a scan
// - sample four keypad data lines on input bits 0 to 3 per selection
// - keep up to sixteen hex digits of keyed input in two result words
// - one digit takes 1 to 4 scan steps; scanning restarts and continues
// - pressing a key sets its one-hot flag bit, held until another key
// - key identity comes from active selection line plus asserted data line
// - every (re)start of execution begins scanning at the first selection line
// - two words form a 16-digit shift register, new digit in lowest nibble
// - while a key stays pressed, all other keys are ignored until release
`ifndef HKS_CFG_SVH
`define HKS_CFG_SVH

`define HKS_ADDR_W 8
`define HKS_OFS_DIGITS_LO 8'h00
`define HKS_OFS_DIGITS_HI 8'h04
`define HKS_OFS_KEY_FLAGS 8'h08
`define HKS_OFS_CTRL 8'h0C
`define HKS_OFS_STATUS 8'h10
`define HKS_OFS_INT_STATUS 8'h14
`define HKS_OFS_INT_MASK 8'h18

`define HKS_CTRL_RUN_BIT 0
`define HKS_CTRL_CLEAR_BIT 1
`define HKS_STAT_HELD_BIT 0
`define HKS_STAT_CODE_LSB 4
`define HKS_STAT_SEL_LSB 8
`define HKS_INT_DIGIT_BIT 0
`define HKS_INT_RELEASE_BIT 1

`define HKS_RST_DIGITS 32'h0000_0000
`define HKS_RST_FLAGS 16'h0000
`define HKS_RST_MASK 2'h0

`define HKS_CLK_NS 20
`define HKS_STEP_NS 1000
`define HKS_STEP_CYC ((`HKS_STEP_NS + `HKS_CLK_NS - 1) / `HKS_CLK_NS)
`define HKS_STEP_W 8

`endif

// file: hks_keypad_model.sv
// passive 4x4 key matrix: a pressed key joins its selection line to its data line
// assumes active-high lines and that open data lines read low through pull-downs
`timescale 1ns/1ps
`default_nettype none

module hks_keypad_model
(
  input wire logic [3:0] sel_i,
  input wire logic [15:0] keys_i,
  output logic [3:0] data_o
);
  always_comb
  begin
    // lines answer at once, so the pins are settled well inside every scan step
    data_o = 4'h0;
    for (int k = 0; k < 16; k++)
    begin
      if (keys_i[k] && sel_i[k / 4])
        data_o[k % 4] = 1'b1;
    end
  end
endmodule : hks_keypad_model

`default_nettype wire

// file: hks_keypad_scan.sv
// hexadecimal keypad scanner: drives selection lines, decodes keys,
// shifts digits into a 16-digit register and flags the last key
// assumes a passive 4x4 key matrix with active-high selection and data lines,
// and a register master that never issues read and write strobes together
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "hks_cfg.svh"

module hks_keypad_scan
#(
  parameter int STEP_CYCLES = `HKS_STEP_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] key_data_i,
  output logic [3:0] key_select_o,
  input wire hks_pkg::hks_addr_t reg_addr_i,
  input wire hks_pkg::hks_word_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output hks_pkg::hks_word_t reg_rdata_o,
  output logic irq_o
);
  import hks_pkg::*;

  localparam logic [`HKS_STEP_W-1:0] STEP_LAST = `HKS_STEP_W'(STEP_CYCLES - 1);

  typedef struct packed
  {
    logic run;
    hks_work_s work;
    logic [3:0] sel_oh;
    hks_word_t digits_lo;
    hks_word_t digits_hi;
    logic [15:0] flags;
    logic [1:0] int_sts;
    logic [1:0] int_msk;
    hks_word_t rdata;
    logic irq;
  } hks_state_s;

  hks_state_s q;
  hks_state_s d;

  hks_sync_if sync_if ();

  assign sync_if.raw = key_data_i;

  hks_pin_sync u_pin_sync
  (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .sync(sync_if.filt_mp)
  );

  // lowest asserted data line wins when several keys share one selection
  function automatic logic [1:0] first_line(input logic [3:0] lines);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (lines[i])
      begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction : first_line

  // fixed table: selection index is the high pair, data index the low pair
  function automatic hks_nib_t key_code(input logic [1:0] sel, input logic [1:0] line);
    return {sel, line};
  endfunction : key_code

  logic step_tick;
  logic [3:0] lines;
  logic [1:0] line_idx;
  hks_nib_t new_code;
  logic held_line;
  logic digit_ev;
  logic release_ev;
  logic run_start;
  logic wr_ctrl;
  logic rd_sts;
  hks_word_t rd_mux;

  always_comb
  begin
    d = q;
    lines = sync_if.filt;
    line_idx = first_line(lines);
    new_code = key_code(q.work.sel_idx, line_idx);
    held_line = lines[q.work.held_code[1:0]];
    digit_ev = 1'b0;
    release_ev = 1'b0;
    step_tick = q.run && (q.work.step_cnt == STEP_LAST);
    wr_ctrl = reg_wr_i && (reg_addr_i == `HKS_OFS_CTRL);
    run_start = wr_ctrl && reg_wdata_i[`HKS_CTRL_RUN_BIT] && !q.run;
    rd_sts = reg_rd_i && (reg_addr_i == `HKS_OFS_INT_STATUS);

    // step timer stands for one controller execution cycle; the pins settle within it
    if (q.run)
    begin
      d.work.step_cnt = step_tick ? '0 : q.work.step_cnt + `HKS_STEP_W'(1);
    end

    if (step_tick)
    begin
      unique case (q.work.mode)
        HKS_SEARCH:
        begin
          if (|lines)
          begin
            digit_ev = 1'b1;
            d.digits_hi = {q.digits_hi[27:0], q.digits_lo[31:28]};
            d.digits_lo = {q.digits_lo[27:0], new_code};
            d.flags = 16'h0001 << new_code;
            d.work.held_code = new_code;
            d.work.mode = HKS_HELD;
          end
          else
          begin
            d.work.sel_idx = q.work.sel_idx + 2'h1;
          end
        end
        HKS_HELD:
        begin
          // only the held key's line is watched, so other presses go unseen
          if (!held_line)
          begin
            release_ev = 1'b1;
            d.work.mode = HKS_SEARCH;
            d.work.sel_idx = 2'h0;
          end
        end
      endcase
    end

    if (wr_ctrl)
    begin
      d.run = reg_wdata_i[`HKS_CTRL_RUN_BIT];
      // a fresh start or an explicit clear puts the work word back at line one
      if (run_start || reg_wdata_i[`HKS_CTRL_CLEAR_BIT])
      begin
        d.work = '{mode: HKS_SEARCH, sel_idx: 2'h0, step_cnt: '0, held_code: 4'h0};
        digit_ev = 1'b0;
        release_ev = 1'b0;
      end
    end
    if (reg_wr_i && (reg_addr_i == `HKS_OFS_INT_MASK))
    begin
      d.int_msk = reg_wdata_i[1:0];
    end

    // selection output follows the work word; held state keeps its row driven
    d.sel_oh = d.run ? (4'h1 << d.work.sel_idx) : 4'h0;

    // an event landing on the clearing read survives: set wins
    d.int_sts = rd_sts ? 2'h0 : q.int_sts;
    d.int_sts[`HKS_INT_DIGIT_BIT] = d.int_sts[`HKS_INT_DIGIT_BIT] | digit_ev;
    d.int_sts[`HKS_INT_RELEASE_BIT] = d.int_sts[`HKS_INT_RELEASE_BIT] | release_ev;
    d.irq = |(d.int_sts & d.int_msk);

    rd_mux = 32'h0000_0000;
    unique case (reg_addr_i)
      `HKS_OFS_DIGITS_LO:
      begin
        rd_mux = q.digits_lo;
      end
      `HKS_OFS_DIGITS_HI:
      begin
        rd_mux = q.digits_hi;
      end
      `HKS_OFS_KEY_FLAGS:
      begin
        rd_mux = {16'h0000, q.flags};
      end
      `HKS_OFS_CTRL:
      begin
        rd_mux = {31'h0000_0000, q.run};
      end
      `HKS_OFS_STATUS:
      begin
        rd_mux[`HKS_STAT_HELD_BIT] = (q.work.mode == HKS_HELD);
        rd_mux[`HKS_STAT_CODE_LSB +: 4] = q.work.held_code;
        rd_mux[`HKS_STAT_SEL_LSB +: 2] = q.work.sel_idx;
      end
      `HKS_OFS_INT_STATUS:
      begin
        rd_mux = {30'h0000_0000, q.int_sts};
      end
      `HKS_OFS_INT_MASK:
      begin
        rd_mux = {30'h0000_0000, q.int_msk};
      end
      default:
      begin
        rd_mux = 32'h0000_0000;
      end
    endcase
    // read data stand for exactly one cycle after the strobe
    d.rdata = reg_rd_i ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      q.run <= 1'b0;
      q.work <= '{mode: HKS_SEARCH, sel_idx: 2'h0, step_cnt: '0, held_code: 4'h0};
      q.sel_oh <= 4'h0;
      q.digits_lo <= `HKS_RST_DIGITS;
      q.digits_hi <= `HKS_RST_DIGITS;
      q.flags <= `HKS_RST_FLAGS;
      q.int_sts <= 2'h0;
      q.int_msk <= `HKS_RST_MASK;
      q.rdata <= 32'h0000_0000;
      q.irq <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  assign key_select_o = q.sel_oh;
  assign reg_rdata_o = q.rdata;
  assign irq_o = q.irq;
endmodule : hks_keypad_scan

`default_nettype wire

// file: hks_keypad_scan_assertions.sv
// port checker for the keypad scanner, bound into its top module
// assumes STEP_CYCLES is handed on from the instance that it watches
`timescale 1ns/1ps
`default_nettype none
`include "hks_cfg.svh"

module hks_keypad_scan_assertions
#(
  parameter int STEP_CYCLES = 50
)
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] key_select_o,
  input wire hks_pkg::hks_addr_t reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire hks_pkg::hks_word_t reg_rdata_o,
  input wire logic irq_o
);
  import hks_pkg::*;
  logic [3:0] prev_q;
  int stay_q;
  logic moved;
  logic rd_at;
  assign moved = prev_q != 4'h0 && key_select_o != 4'h0 && key_select_o != prev_q;
  always_ff @(posedge sys_clk_i)
  begin
    prev_q <= sys_rst_i ? 4'h0 : key_select_o;
    stay_q <= (sys_rst_i || key_select_o != prev_q) ? 0 : stay_q + 1;
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_SEL_ONEHOT: assert property (key_select_o != 4'h0 |-> $onehot(key_select_o))
    else $error("select not one-hot");
  AST_SEL_ADVANCE: assert property (moved |-> key_select_o == 4'h1 || key_select_o == {prev_q[2:0], 1'b0})
    else $error("select skipped");
  // held rows stretch a step, so only a lower bound holds
  AST_SEL_STEP: assert property (moved && key_select_o != 4'h1 |-> stay_q >= STEP_CYCLES - 1)
    else $error("step too short");
  AST_SEL_START: assert property (prev_q == 4'h0 && key_select_o != 4'h0 |-> key_select_o == 4'h1 && $past(reg_wr_i))
    else $error("scan start wrong");
  AST_SEL_STILL: assert property (key_select_o == 4'h0 && !reg_wr_i |=> key_select_o == 4'h0)
    else $error("select woke alone");
  AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside slot");
  AST_FLAGS_ONEHOT: assert property ($past(reg_rd_i) && $past(reg_addr_i) == `HKS_OFS_KEY_FLAGS && reg_rdata_o != '0 |-> $onehot(reg_rdata_o))
    else $error("key flags not one-hot");
  AST_HELD_ROW: assert property ($past(reg_rd_i) && $past(reg_addr_i) == `HKS_OFS_STATUS && reg_rdata_o[0] |-> reg_rdata_o[7:6] == reg_rdata_o[9:8])
    else $error("held code row mismatch");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(reg_rd_i) || $past(reg_wr_i))
    else $error("irq dropped alone");
endmodule : hks_keypad_scan_assertions

bind hks_keypad_scan hks_keypad_scan_assertions #(.STEP_CYCLES(STEP_CYCLES)) hks_keypad_scan_assertions_i
(
  .sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i),
  .key_select_o(key_select_o),
  .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .irq_o(irq_o)
);

`default_nettype wire

// file: hks_keypad_scan_tb.sv
// self-checking bench for the keypad scanner with a key matrix model
// assumes design, model and checker files are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "hks_cfg.svh"

module hks_keypad_scan_tb;
  import hks_pkg::*;
  localparam int STEP = 8;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] key_data;
  logic [3:0] key_select;
  hks_addr_t reg_addr = '0;
  hks_word_t reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  hks_word_t reg_rdata;
  logic irq;
  logic [15:0] keys = 16'h0;
  hks_word_t digits = '0;
  hks_word_t rv;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;

  always #10 sys_clk = ~sys_clk;

  hks_keypad_scan #(.STEP_CYCLES(STEP)) hks_keypad_scan_i
  (
    .sys_clk_i(sys_clk),
    .sys_rst_i(sys_rst),
    .key_data_i(key_data),
    .key_select_o(key_select),
    .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata),
    .irq_o(irq)
  );

  hks_keypad_model hks_keypad_model_i
  (
    .sel_i(key_select),
    .keys_i(keys),
    .data_o(key_data)
  );

  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // a hang would otherwise stall the run silently
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input hks_addr_t a, input hks_word_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input hks_addr_t a, output hks_word_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    check("irq_o", 32'h1, {31'h0, irq});
    check("digit time", 32'h1, {31'h0, n <= 5 * STEP});
  endtask : wait_irq

  task automatic scen_reset();
    for (int a = 0; a < 32; a += 4)
    begin
      rd(a[7:0], rv);
      check("reg after reset", 32'h0, rv);
    end
    check("select after reset", 32'h0, {28'h0, key_select});
  endtask : scen_reset

  task automatic scen_hold();
    wr(`HKS_OFS_CTRL, 32'h3);
    @(negedge sys_clk);
    check("first select", 32'h1, {28'h0, key_select});
    @(posedge sys_clk);
    keys <= 16'h0020;
    repeat (6 * STEP) @(posedge sys_clk);
    keys <= 16'h0021;
    @(negedge sys_clk);
    check("masked irq", 32'h0, {31'h0, irq});
    wr(`HKS_OFS_INT_MASK, 32'h3);
    @(negedge sys_clk);
    check("unmasked irq", 32'h1, {31'h0, irq});
    rd(`HKS_OFS_INT_STATUS, rv);
    check("digit event", 32'h1, rv);
    repeat (6 * STEP) @(posedge sys_clk);
    rd(`HKS_OFS_DIGITS_LO, rv);
    check("other key ignored", 32'h5, rv);
    @(posedge sys_clk);
    keys <= 16'h0001;
    repeat (6 * STEP) @(posedge sys_clk);
    rd(`HKS_OFS_DIGITS_LO, rv);
    check("digit after release", 32'h50, rv);
    rd(`HKS_OFS_KEY_FLAGS, rv);
    check("key flags", 32'h1, rv);
    @(posedge sys_clk);
    keys <= 16'h0;
    repeat (6 * STEP) @(posedge sys_clk);
    rd(`HKS_OFS_INT_STATUS, rv);
    check("sticky events", 32'h3, rv);
    digits = 32'h50;
  endtask : scen_hold

  task automatic press(input logic [3:0] c);
    @(posedge sys_clk);
    keys <= 16'h1 << c;
    wait_irq();
    rd(`HKS_OFS_INT_STATUS, rv);
    check("digit event", 32'h1, rv);
    digits = {digits[27:0], c};
    rd(`HKS_OFS_DIGITS_LO, rv);
    check("digits lo", digits, rv);
    rd(`HKS_OFS_KEY_FLAGS, rv);
    check("key flags", 32'h1 << c, rv);
    rd(`HKS_OFS_STATUS, rv);
    check("held status", {22'h0, c[3:2], c, 3'h0, 1'b1}, rv);
    @(posedge sys_clk);
    keys <= 16'h0;
    wait_irq();
    rd(`HKS_OFS_INT_STATUS, rv);
    check("release event", 32'h2, rv);
  endtask : press

  task automatic scen_restart();
    repeat (2 * STEP + 3) @(posedge sys_clk);
    wr(`HKS_OFS_CTRL, 32'h3);
    @(negedge sys_clk);
    check("restart select", 32'h1, {28'h0, key_select});
    wr(`HKS_OFS_CTRL, 32'h0);
    @(negedge sys_clk);
    check("stopped select", 32'h0, {28'h0, key_select});
  endtask : scen_restart

  initial
  begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    scen_reset();
    scen_hold();
    for (int c = 0; c < 16; c++)
      press(c[3:0]);
    rd(`HKS_OFS_DIGITS_HI, rv);
    check("digits hi", 32'h01234567, rv);
    scen_restart();
    end_of_test();
  end
endmodule : hks_keypad_scan_tb

`default_nettype wire

// file: hks_pin_sync.sv
// three-flop synchroniser with agreement filter for the keypad data lines
// assumes raw lines are asynchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none

module hks_pin_sync
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  hks_sync_if.filt_mp sync
);
  import hks_pkg::*;

  typedef struct packed
  {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
  } hks_sync_s;

  hks_sync_s q;
  hks_sync_s d;
  logic [3:0] agreed;

  // a change only counts once stages two and three agree; stage one feeds stage two only
  for (genvar b = 0; b < 4; b++)
  begin : g_bit
    assign agreed[b] = (q.s2[b] == q.s3[b]) ? q.s3[b] : q.filt[b];
  end

  always_comb
  begin
    d = q;
    d.s1 = sync.raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = agreed;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign sync.filt = q.filt;
endmodule : hks_pin_sync

`default_nettype wire

// file: hks_pkg.sv
// types shared by the keypad scanner modules
// assumes hks_cfg.svh is on the include path
`include "hks_cfg.svh"

package hks_pkg;

  typedef logic [`HKS_ADDR_W-1:0] hks_addr_t;
  typedef logic [31:0] hks_word_t;
  typedef logic [3:0] hks_nib_t;

  typedef enum logic
  {
    HKS_SEARCH,
    HKS_HELD
  } hks_scan_e;

  // the scan work word: selection position, step timer and held key
  typedef struct packed
  {
    hks_scan_e mode;
    logic [1:0] sel_idx;
    logic [`HKS_STEP_W-1:0] step_cnt;
    hks_nib_t held_code;
  } hks_work_s;

endpackage : hks_pkg

// file: hks_sync_if.sv
// carrier between the scanner and its pin synchroniser
// raw keypad data lines in, filtered data lines out
`timescale 1ns/1ps
`default_nettype none

interface hks_sync_if;
  logic [3:0] raw;
  logic [3:0] filt;

  modport filt_mp
  (
    input raw,
    output filt
  );

  modport user_mp
  (
    output raw,
    input filt
  );
endinterface : hks_sync_if

`default_nettype wire
